// file: report_printer_serial_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module report_printer_serial_port_bench;
  import rps_pkg::*;
  typedef struct packed {
    logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] wr; logic [1:0] rr;
  } rps_row_s;
  // Register writes beside the read-back and responses they should give
  localparam rps_row_s ROWS [8] = '{
    '{OFS_INTERVAL, 32'h0000_0000, 32'h0000_0001, RESP_OKAY, RESP_OKAY},
    '{OFS_INTERVAL, 32'h0000_07D0, 32'h0000_05A0, RESP_OKAY, RESP_OKAY},
    '{OFS_INTERVAL, 32'h0000_05A0, 32'h0000_05A0, RESP_OKAY, RESP_OKAY},
    '{OFS_INTERVAL, 32'h0000_0003, 32'h0000_0003, RESP_OKAY, RESP_OKAY},
    '{OFS_START, 32'h0000_07FF, 32'h0000_059F, RESP_OKAY, RESP_OKAY},
    '{OFS_REMAIN, 32'h0000_0055, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
    '{8'h20, 32'h0000_1234, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR},
    '{8'h05, 32'h0000_1234, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR}
  };
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  rps_axi_req_s axi_req = '0;
  rps_axi_rsp_s axi_rsp;
  logic hold = 1'b0;
  logic busy_n;
  logic shutdown = 1'b0;
  logic txd;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [1:0] ws;
  int err_count = 0;
  int samples_checked = 0;
  int cycle_count = 0;
  int t0;

  rps_printer_port #(.BAUD_DIV(4), .CLKS_PER_SEC(2), .DEPTH(4)) i_rps_printer_port (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_axi(axi_req), .o_axi(axi_rsp),
    .i_busy_n(busy_n), .i_shutdown(shutdown), .o_txd(txd));
  rps_printer_model #(.BAUD_DIV(4)) i_rps_printer_model (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_rxd(txd), .i_hold(hold),
    .o_busy_n(busy_n));

  // 250 MHz clock
  initial
  begin
    forever #2 i_clock = ~i_clock;
  end

  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge i_clock)
  begin
    cycle_count++;
    if (cycle_count == 60000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    ws = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge i_clock);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    rd = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // Own start mark, so a caller's interval timing in t0 survives
  task automatic wait_bytes(input int n);
    int ts;
    ts = cycle_count;
    while (i_rps_printer_model.rx_q.size() < n && cycle_count - ts < 3000)
      @(posedge i_clock);
  endtask

  // Body byte j is 8'h66 plus j, so stream byte i past the header is 8'h60 plus i
  task automatic push_body(input int n);
    for (int j = 0; j < n; j++)
      axi_write(OFS_DATA, 32'h0000_0066 + j);
  endtask

  task automatic check_report(input logic [7:0] fmt, input logic [7:0] kind, input int nb);
    logic [7:0] e [6];
    e = '{fmt, hexc(4'h3), hexc(4'hC), kind, CHAR_CR, CHAR_LF};
    wait_bytes(6 + nb);
    check(i_rps_printer_model.rx_q.size(), 6 + nb);
    for (int i = 0; i < 6 + nb; i++)
      check(i_rps_printer_model.rx_q[i], (i < 6) ? e[i] : 8'h60 + i);
    i_rps_printer_model.rx_q.delete();
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    foreach (ROWS[k])
    begin
      axi_write(ROWS[k].a, ROWS[k].w);
      check(ws, ROWS[k].wr);
      axi_read(ROWS[k].a);
      check(rd, ROWS[k].r);
      check(rs, ROWS[k].rr);
    end
    axi_write(OFS_ID, 32'h0000_003C);
    // Every printer type; odd types ask for the history report
    for (int t = 0; t < 4; t++)
    begin
      push_body(t);
      axi_write(OFS_CTRL, {26'h0, t[0], 2'b01, t[1:0], 1'b0});
      check_report(FMT_CODE[t], t[0] ? KIND_HISTORY : KIND_STATUS, t);
    end
    // Busy before the report, then busy caught in mid-frame
    hold <= 1'b1;
    // Four queued plus one in the output stage fills the queue
    push_body(5);
    axi_read(OFS_STATUS);
    check(rd[5:0], 6'h08);
    axi_write(OFS_CTRL, 32'h0000_0008);
    repeat (200) @(posedge i_clock);
    check(i_rps_printer_model.rx_q.size(), 0);
    hold <= 1'b0;
    t0 = cycle_count;
    while (txd !== 1'b0 && cycle_count - t0 < 100) @(posedge i_clock);
    hold <= 1'b1;
    repeat (200) @(posedge i_clock);
    check(i_rps_printer_model.rx_q.size(), 1);
    hold <= 1'b0;
    check_report(FMT_CODE[0], KIND_STATUS, 5);
    // Shutdown snapshot only with a printer present
    axi_write(OFS_CTRL, 32'h0000_0000);
    shutdown <= 1'b1;
    @(posedge i_clock);
    shutdown <= 1'b0;
    repeat (300) @(posedge i_clock);
    check(i_rps_printer_model.rx_q.size(), 0);
    axi_write(OFS_CTRL, 32'h0000_0014);
    shutdown <= 1'b1;
    @(posedge i_clock);
    shutdown <= 1'b0;
    check_report(FMT_CODE[2], KIND_SHUTDOWN, 0);
    // Scheduled logging: start at minute 2, then every 3 minutes of 120 cycles
    axi_write(OFS_CLOCK, 32'h0000_0000);
    axi_write(OFS_START, 32'h0000_0002);
    axi_write(OFS_CTRL, 32'h0000_0001);
    wait_bytes(1);
    t0 = cycle_count;
    axi_read(OFS_REMAIN);
    check(rd, 32'h0000_0003);
    check_report(FMT_CODE[0], KIND_STATUS, 0);
    wait_bytes(1);
    check((cycle_count - t0 >= 355) && (cycle_count - t0 <= 365), 1'b1);
    check_report(FMT_CODE[0], KIND_STATUS, 0);
    axi_write(OFS_CTRL, 32'h0000_0000);
    axi_read(OFS_REMAIN);
    check(rd, 32'h0000_0000);
    repeat (500) @(posedge i_clock);
    check(i_rps_printer_model.rx_q.size(), 0);
    check(i_rps_printer_model.frame_errs, 0);
    // Second reset restores defaults and an idle line
    i_reset_n <= 1'b0;
    repeat (10) @(posedge i_clock);
    i_reset_n <= 1'b1;
    check(txd, 1'b1);
    axi_read(OFS_INTERVAL);
    check(rd, 32'h0000_003C);
    axi_read(OFS_ID);
    check(rd, 32'h0000_0000);
    axi_read(OFS_CTRL);
    check(rd, 32'h0000_0000);
    test_done();
  end
endmodule // report_printer_serial_port_bench
`default_nettype wire

// file: rps_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module rps_fifo
  import rps_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } rps_fifo_s;

  rps_fifo_s st;
  rps_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic load;

  // Full is the stored count, so the writer sees honest back-pressure
  assign o_ready = st.cnt != (AW+1)'(DEPTH);
  assign o_valid = st.ov;
  assign o_data = st.od;
  assign push = i_valid && o_ready;
  assign load = (st.cnt != '0) && (!st.ov || i_ready);

  // Pointers, count and registered read stage
  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wr = st.wr + 1'b1;
    if (load)
    begin
      next_st.rd = st.rd + 1'b1;
      next_st.od = mem[st.rd];
      next_st.ov = 1'b1;
    end
    else if (i_ready)
      next_st.ov = 1'b0;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  // Storage has no reset; contents are valid only behind the count
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[st.wr] <= i_data;
  end
endmodule // rps_fifo
`default_nettype wire

// file: rps_pkg.sv
`default_nettype none
package rps_pkg;
  // Link framing and timing
  localparam int CLOCK_HZ = 250_000_000;
  localparam int BAUD_RATE = 19200;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  // Nearest whole count of clock cycles per bit
  localparam int BAUD_DIV_DEF = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int SEC_PER_MIN = 60;
  localparam logic [10:0] MIN_PER_DAY = 11'h05A0;
  localparam logic [10:0] INTERVAL_MIN = 11'h0001;
  localparam logic [10:0] INTERVAL_MAX = 11'h05A0;
  localparam int FIFO_DEPTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ID = 8'h04;
  localparam logic [7:0] OFS_INTERVAL = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_CLOCK = 8'h10;
  localparam logic [7:0] OFS_REMAIN = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1C;

  // Control field positions
  localparam int CTRL_LOG_EN = 0;
  localparam int CTRL_PTYPE = 1;
  localparam int CTRL_REQ = 3;
  localparam int CTRL_PRESENT = 4;
  localparam int CTRL_HIST = 5;

  // Values after reset
  localparam logic [10:0] RST_INTERVAL = 11'h003C;
  localparam logic [10:0] RST_START = 11'h0000;
  localparam logic [7:0] RST_ID = 8'h00;

  // Formatting lead-in byte for each printer type
  localparam logic [7:0] FMT_CODE [4] = '{8'h0C, 8'h1B, 8'h12, 8'h0E};
  // Report kind letters printed after the identification
  localparam logic [7:0] KIND_STATUS = 8'h0053;
  localparam logic [7:0] KIND_HISTORY = 8'h0048;
  localparam logic [7:0] KIND_SHUTDOWN = 8'h0044;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_CODE = 3'b001, SQ_ID_HI = 3'b010, SQ_ID_LO = 3'b011,
    SQ_KIND = 3'b100, SQ_CR = 3'b101, SQ_LF = 3'b110, SQ_BODY = 3'b111
  } rps_seq_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } rps_tx_e;

  // AXI4-Lite request and answer groups
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } rps_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rps_axi_rsp_s;
endpackage
`default_nettype wire

// file: rps_printer_model.sv
`timescale 1ns/1ps
`default_nettype none
module rps_printer_model
#(
  parameter int BAUD_DIV = 4
)(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_rxd,
  input wire logic i_hold,
  output logic o_busy_n
);
  logic [7:0] rx_q[$];
  int frame_errs = 0;
  logic [7:0] shift;
  // Busy pin low while the receive buffer is held full
  assign o_busy_n = ~i_hold;
  // Receiver samples mid-bit, so a short or long bit shows as a bad byte
  initial
  begin
    forever
    begin
      @(negedge i_rxd);
      if (i_reset_n)
      begin
        repeat (BAUD_DIV / 2) @(posedge i_clock);
        if (i_rxd) frame_errs++;
        for (int b = 0; b < 8; b++)
        begin
          repeat (BAUD_DIV) @(posedge i_clock);
          shift[b] = i_rxd;
        end
        repeat (BAUD_DIV) @(posedge i_clock);
        if (!i_rxd) frame_errs++;
        rx_q.push_back(shift);
      end
    end
  end
endmodule // rps_printer_model
`default_nettype wire

// file: rps_printer_port.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module rps_printer_port
  import rps_pkg::*;
#(
  parameter int BAUD_DIV = BAUD_DIV_DEF,
  parameter int CLKS_PER_SEC = CLOCK_HZ,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire rps_axi_req_s i_axi,
  output rps_axi_rsp_s o_axi,
  input wire logic i_busy_n,
  input wire logic i_shutdown,
  output logic o_txd
);
  typedef struct packed {
    rps_axi_rsp_s bus;
    logic log_en;
    logic [1:0] ptype;
    logic present;
    logic [7:0] id;
    logic [10:0] interval;
    logic [10:0] start;
    logic [10:0] now;
    logic [10:0] remain;
    logic started;
    logic [27:0] tick;
    logic [5:0] sec;
    logic sched_pend;
    logic shut_pend;
    logic req_pend;
    logic req_hist;
    logic [7:0] kind;
    rps_seq_e seq;
    rps_tx_e tx;
    logic [13:0] baud;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic txd;
    logic [1:0] busy_sync;
  } rps_state_s;

  rps_state_s st;
  rps_state_s next_st;
  logic rdy_s;
  logic f_in_ready;
  logic f_push;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  logic launch;
  logic [7:0] tx_byte;
  logic byte_ok;
  logic sched_fire;

  assign o_axi = st.bus;
  assign o_txd = st.txd;
  assign rdy_s = st.busy_sync[1];

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'h0A) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
  endfunction

  // Readback of every register but the data port; it and unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input logic [7:0] a, input rps_state_s s,
                                           input logic fv, input logic fr);
    reg_read = '0;
    if (a == OFS_CTRL)
      reg_read = {26'h0, s.req_hist, s.present, s.req_pend, s.ptype, s.log_en};
    else if (a == OFS_ID)
      reg_read = {24'h0, s.id};
    else if (a == OFS_INTERVAL)
      reg_read = {21'h0, s.interval};
    else if (a == OFS_START)
      reg_read = {21'h0, s.start};
    else if (a == OFS_CLOCK)
      reg_read = {21'h0, s.now};
    else if (a == OFS_REMAIN)
      reg_read = {21'h0, s.remain};
    else if (a == OFS_STATUS)
      reg_read = {26'h0, s.shut_pend, !fv, !fr, s.seq != SQ_IDLE, s.tx != TX_IDLE, s.busy_sync[1]};
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a <= OFS_DATA) && (a[1:0] == 2'b00);
  endfunction

  // Report byte offered by the sequencer in its present step
  always_comb
  begin
    tx_byte = 8'h00;
    byte_ok = 1'b1;
    case (st.seq)
      SQ_CODE: tx_byte = FMT_CODE[st.ptype];
      SQ_ID_HI: tx_byte = hex_char(st.id[7:4]);
      SQ_ID_LO: tx_byte = hex_char(st.id[3:0]);
      SQ_KIND: tx_byte = st.kind;
      SQ_CR: tx_byte = CHAR_CR;
      SQ_LF: tx_byte = CHAR_LF;
      SQ_BODY:
      begin
        tx_byte = f_data;
        byte_ok = f_valid;
      end
      default: byte_ok = 1'b0;
    endcase
  end

  // A new frame only starts while the printer reports ready
  assign launch = (st.tx == TX_IDLE) && rdy_s && byte_ok;
  assign f_pop = launch && (st.seq == SQ_BODY);

  // Scheduler fires on the minute that matches start, then every interval
  assign sched_fire = st.log_en && (st.tick == 28'(CLKS_PER_SEC - 1))
    && (st.sec == 6'(SEC_PER_MIN - 1))
    && (st.started ? (st.remain == INTERVAL_MIN)
       : ((st.now == MIN_PER_DAY - 11'h0001 ? 11'h0000 : st.now + 11'h0001) == st.start));

  // Bus slave, scheduler, sequencer and transmitter share one state record
  always_comb
  begin
    logic [31:0] cur;
    logic [31:0] mask;
    logic [31:0] wd;
    logic wr_go;
    logic min_tick;
    logic [10:0] new_now;
    logic req_wr;
    cur = '0;
    mask = '0;
    wd = '0;
    wr_go = 1'b0;
    min_tick = 1'b0;
    new_now = st.now;
    req_wr = 1'b0;
    next_st = st;
    f_push = 1'b0;
    next_st.busy_sync = {st.busy_sync[0], i_busy_n};
    next_st.bus.awready = 1'b0;
    next_st.bus.wready = 1'b0;
    next_st.bus.arready = 1'b0;

    // Write: both channels together; data writes wait for room in the queue
    if (st.bus.bvalid && i_axi.bready)
      next_st.bus.bvalid = 1'b0;
    if (!st.bus.bvalid && !st.bus.awready && i_axi.awvalid && i_axi.wvalid
        && (i_axi.awaddr != OFS_DATA || f_in_ready))
    begin
      wr_go = 1'b1;
      next_st.bus.awready = 1'b1;
      next_st.bus.wready = 1'b1;
      next_st.bus.bvalid = 1'b1;
      next_st.bus.bresp = known(i_axi.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    cur = reg_read(i_axi.awaddr, st, f_valid, f_in_ready);
    mask = {{8{i_axi.wstrb[3]}}, {8{i_axi.wstrb[2]}}, {8{i_axi.wstrb[1]}}, {8{i_axi.wstrb[0]}}};
    wd = (i_axi.wdata & mask) | (cur & ~mask);
    if (wr_go)
    begin
      if (i_axi.awaddr == OFS_CTRL)
      begin
        next_st.log_en = wd[CTRL_LOG_EN];
        next_st.ptype = wd[CTRL_PTYPE +: 2];
        next_st.present = wd[CTRL_PRESENT];
        // Applied after the sequencer so a request never meets its own clear
        req_wr = wd[CTRL_REQ] && i_axi.wstrb[0];
      end
      else if (i_axi.awaddr == OFS_ID)
        next_st.id = wd[7:0];
      else if (i_axi.awaddr == OFS_INTERVAL)
        next_st.interval = (wd[10:0] < INTERVAL_MIN) ? INTERVAL_MIN
          : (wd[31:11] != '0 || wd[10:0] > INTERVAL_MAX) ? INTERVAL_MAX : wd[10:0];
      else if (i_axi.awaddr == OFS_START)
        next_st.start = (wd[10:0] >= MIN_PER_DAY) ? MIN_PER_DAY - 11'h0001 : wd[10:0];
      else if (i_axi.awaddr == OFS_CLOCK)
        next_st.now = (wd[10:0] >= MIN_PER_DAY) ? MIN_PER_DAY - 11'h0001 : wd[10:0];
      else if (i_axi.awaddr == OFS_DATA)
        f_push = 1'b1;
    end

    // Read: answer comes with arready, held until rready
    if (st.bus.rvalid && i_axi.rready)
      next_st.bus.rvalid = 1'b0;
    if (!st.bus.rvalid && !st.bus.arready && i_axi.arvalid)
    begin
      next_st.bus.arready = 1'b1;
      next_st.bus.rvalid = 1'b1;
      next_st.bus.rdata = reg_read(i_axi.araddr, st, f_valid, f_in_ready);
      next_st.bus.rresp = known(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Time of day: seconds from the clock, minutes wrap at midnight
    if (st.tick == 28'(CLKS_PER_SEC - 1))
    begin
      next_st.tick = '0;
      next_st.sec = st.sec + 6'h01;
      if (st.sec == 6'(SEC_PER_MIN - 1))
      begin
        next_st.sec = '0;
        min_tick = 1'b1;
      end
    end
    else
      next_st.tick = st.tick + 28'h000_0001;
    if (min_tick)
    begin
      new_now = (st.now == MIN_PER_DAY - 11'h0001) ? 11'h0000 : st.now + 11'h0001;
      next_st.now = new_now;
    end

    // Countdown to the next scheduled print
    if (!st.log_en)
    begin
      next_st.started = 1'b0;
      next_st.remain = '0;
    end
    else if (sched_fire)
    begin
      next_st.started = 1'b1;
      next_st.remain = st.interval;
    end
    else if (min_tick)
      next_st.remain = st.started ? st.remain - 11'h0001
        : (st.start >= new_now) ? st.start - new_now
        : st.start + MIN_PER_DAY - new_now;

    // Report sequencer; shutdown outranks requests, requests outrank logging
    case (st.seq)
      SQ_IDLE:
      begin
        if (st.shut_pend)
        begin
          next_st.shut_pend = 1'b0;
          next_st.kind = KIND_SHUTDOWN;
          next_st.seq = SQ_CODE;
        end
        else if (st.req_pend)
        begin
          next_st.req_pend = 1'b0;
          next_st.kind = st.req_hist ? KIND_HISTORY : KIND_STATUS;
          next_st.seq = SQ_CODE;
        end
        else if (st.sched_pend)
        begin
          next_st.sched_pend = 1'b0;
          next_st.kind = KIND_STATUS;
          next_st.seq = SQ_CODE;
        end
      end
      SQ_BODY:
      begin
        if (!f_valid && st.tx == TX_IDLE)
          next_st.seq = SQ_IDLE;
      end
      default:
      begin
        if (launch)
          next_st.seq = rps_seq_e'(st.seq + 3'b001);
      end
    endcase

    // Events set after the clears so a same-cycle event is kept
    if (sched_fire)
      next_st.sched_pend = 1'b1;
    if (i_shutdown && st.present)
      next_st.shut_pend = 1'b1;
    if (!st.log_en)
      next_st.sched_pend = 1'b0;
    if (req_wr)
    begin
      next_st.req_pend = 1'b1;
      next_st.req_hist = wd[CTRL_HIST];
    end

    // Serial transmitter: start, eight data bits LSB first, one stop bit
    case (st.tx)
      TX_IDLE:
      begin
        next_st.txd = 1'b1;
        if (launch)
        begin
          next_st.tx = TX_START;
          next_st.shift = tx_byte;
          next_st.baud = 14'(BAUD_DIV - 1);
          next_st.txd = 1'b0;
        end
      end
      TX_START, TX_DATA:
      begin
        if (st.baud != '0)
          next_st.baud = st.baud - 14'h0001;
        else
        begin
          next_st.baud = 14'(BAUD_DIV - 1);
          if (st.tx == TX_START)
          begin
            next_st.tx = TX_DATA;
            next_st.bitn = '0;
            next_st.txd = st.shift[0];
          end
          else if (st.bitn == 3'(DATA_BITS - 1))
          begin
            next_st.tx = TX_STOP;
            next_st.txd = 1'b1;
          end
          else
          begin
            next_st.bitn = st.bitn + 3'b001;
            next_st.shift = {1'b0, st.shift[7:1]};
            next_st.txd = st.shift[1];
          end
        end
      end
      TX_STOP:
      begin
        if (st.baud != '0)
          next_st.baud = st.baud - 14'h0001;
        else
          next_st.tx = TX_IDLE;
      end
      default: next_st.tx = TX_IDLE;
    endcase
  end

  // Idle line is mark; ready is assumed false until the pin is seen
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= '0;
      st.txd <= 1'b1;
      st.id <= RST_ID;
      st.interval <= RST_INTERVAL;
      st.start <= RST_START;
    end
    else
      st <= next_st;
  end

  // Report body queue written over the bus, drained one byte per frame
  rps_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_valid(f_push),
    .o_ready(f_in_ready),
    .i_data(i_axi.wdata[7:0]),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_data)
  );

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_report_start;
    st.seq == SQ_IDLE ##1 st.seq != SQ_IDLE;
  endsequence

  sequence s_code_sent;
    st.seq == SQ_CODE && launch;
  endsequence

  chk_busy_holds: assert property ((st.tx == TX_IDLE && !rdy_s) |=> st.tx == TX_IDLE)
    else $error("frame started while printer busy");
  chk_busy_polarity: assert property ($rose(st.tx == TX_START) |-> $past(st.busy_sync[1]))
    else $error("frame started with busy line low");
  chk_frame_bits: assert property ($rose(st.tx == TX_STOP) |-> $past(st.bitn) == 3'd7 && st.txd)
    else $error("stop bit not after eight data bits");
  chk_start_low: assert property (st.tx == TX_START |-> !st.txd)
    else $error("start bit not low");
  chk_frame_finish: assert property ((st.tx == TX_DATA && !rdy_s) |=> st.tx != TX_IDLE)
    else $error("frame cut short by busy");
  chk_interval_range: assert property (st.interval >= INTERVAL_MIN && st.interval <= INTERVAL_MAX)
    else $error("interval outside range");
  chk_sched_reload: assert property (sched_fire |=> st.remain == $past(st.interval) && st.sched_pend)
    else $error("interval not reloaded on scheduled print");
  chk_log_off: assert property (!st.log_en |=> !st.sched_pend && st.remain == '0)
    else $error("scheduled print while logging off");
  chk_shutdown_snap: assert property ((i_shutdown && st.present) |=> st.shut_pend)
    else $error("shutdown snapshot not queued");
  chk_code_first: assert property (s_report_start |-> st.seq == SQ_CODE)
    else $error("report does not open with format code");
  chk_id_next: assert property (s_code_sent |=> st.seq == SQ_ID_HI)
    else $error("identification does not follow format code");
endmodule // rps_printer_port
`default_nettype wire
